/* rtl/atwsel_pkg.sv */
// Constants for the converter scan-wrap and trigger-source control block.
// Assumes an APB slave port with 32-bit data and word-aligned registers.
// What this block does
// - Writing either register aborts the running sequence, never starts one.
// - Wrap field bits 3:0; multi-channel scan returns to channel 0 after it.
// - Wrap codes 1 to 15 pick wrap channel; code zero is reserved.
// - Bit 7 picks trigger from analog channel (0) or dedicated input (1).
// - Trigger channel field bits 3:0 picks analog channel 0 to 15 when bit 7 clear.
// - Without dedicated inputs bit 7 still stores; source stays analog channel.
// - Trigger starts only when enabled; analog source gets its input buffer enabled.
// - Level/edge and polarity: 00 fall, 01 rise, 10 low, 11 high.
package atwsel_pkg;
   localparam logic [11:0] ADDR_WRAP = 12'h000;
   localparam logic [11:0] ADDR_TRIG = 12'h004;
   localparam logic [11:0] ADDR_CTRL = 12'h008;
   localparam logic [11:0] ADDR_STAT = 12'h00c;
   localparam int WRAP_MSB = 3;
   localparam int TSEL_BIT = 7;
   localparam int CH_MSB = 3;
   localparam int CTRL_ETE = 0;
   localparam int CTRL_MULTI = 1;
   localparam int CTRL_LE = 2;
   localparam int CTRL_POL = 3;
   localparam int CTRL_START = 4;
   localparam int STAT_ACT_BIT = 0;
   localparam int STAT_CH_LSB = 4;
   localparam int STAT_CH_MSB = 7;
   localparam int DED_SEL_MSB = 1;
   localparam logic [3:0] WRAP_RST = 4'hf;
   localparam logic [3:0] CTRL_RST = 4'h0;
   localparam logic [3:0] CH_ZERO = 4'h0;
   localparam logic [3:0] DED_LAST = 4'h3;
   typedef enum logic [1:0] {
      ATWSEL_IDLE = 2'b00,
      ATWSEL_RUN = 2'b01
   } atwsel_state_t;
endpackage

/* rtl/atwsel_top.sv */
// Scan wrap and external trigger source control with an APB register slave.
// Assumes conversion completions arrive as one-cycle pulses from the converter core.
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
module atwsel_top #(
   parameter bit HAS_DEDICATED = 1'b1
) (
   input wire logic SYS_CLK_IN,
   input wire logic RST_B_IN,
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [11:0] PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   input wire logic [3:0] PSTRB_IN,
   output logic [31:0] PRDATA_OUT,
   output logic PREADY_OUT,
   output logic PSLVERR_OUT,
   input wire logic [15:0] ANALOG_TRIG_IN,
   input wire logic [3:0] DEDICATED_TRIGGER_INPUTS_IN,
   input wire logic CONV_DONE_IN,
   output logic SEQ_ABORT_OUT,
   output logic SEQ_ACTIVE_OUT,
   output logic [3:0] CUR_CHANNEL_OUT,
   output logic [15:0] DIG_BUF_EN_OUT
);
   logic [3:0] wrap_q;
   logic tsel_q;
   logic [3:0] tch_q;
   logic [3:0] ctrl_q;
   logic [3:0] ch_q;
   logic trig_prev_q;
   logic abort_q;
   atwsel_pkg::atwsel_state_t state_q;
   logic wr_acc, rd_setup, wr_wrap, wr_trig, wr_ctrl, start_sw;
   logic use_ded, trig_raw, trig_fire;
   logic [31:0] rdata_d;

   function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] r);
      addr_hit = (a == r);
   endfunction

   assign wr_acc = PSEL_IN & PENABLE_IN & PWRITE_IN & PSTRB_IN[0];
   // Read data is captured in the setup cycle so it stands through the access cycle
   assign rd_setup = PSEL_IN & ~PENABLE_IN & ~PWRITE_IN;
   assign wr_wrap = wr_acc & addr_hit(PADDR_IN, atwsel_pkg::ADDR_WRAP);
   assign wr_trig = wr_acc & addr_hit(PADDR_IN, atwsel_pkg::ADDR_TRIG);
   assign wr_ctrl = wr_acc & addr_hit(PADDR_IN, atwsel_pkg::ADDR_CTRL);
   assign start_sw = wr_ctrl & PWDATA_IN[atwsel_pkg::CTRL_START];
   assign PREADY_OUT = 1'b1;
   assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~(addr_hit(PADDR_IN, atwsel_pkg::ADDR_WRAP)
      | addr_hit(PADDR_IN, atwsel_pkg::ADDR_TRIG) | addr_hit(PADDR_IN, atwsel_pkg::ADDR_CTRL)
      | addr_hit(PADDR_IN, atwsel_pkg::ADDR_STAT));

   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_B_IN) begin
         wrap_q <= atwsel_pkg::WRAP_RST;
         tsel_q <= 1'b0;
         tch_q <= atwsel_pkg::CH_ZERO;
         ctrl_q <= atwsel_pkg::CTRL_RST;
      end else begin
         if (wr_wrap) begin
            wrap_q <= PWDATA_IN[atwsel_pkg::WRAP_MSB:0];
         end
         if (wr_trig) begin
            tsel_q <= PWDATA_IN[atwsel_pkg::TSEL_BIT];
            tch_q <= PWDATA_IN[atwsel_pkg::CH_MSB:0];
         end
         if (wr_ctrl) begin
            ctrl_q <= PWDATA_IN[atwsel_pkg::CTRL_POL:0];
         end
      end
   end

   always_comb begin
      rdata_d = 32'h0;
      if (addr_hit(PADDR_IN, atwsel_pkg::ADDR_WRAP)) begin
         rdata_d[atwsel_pkg::WRAP_MSB:0] = wrap_q;
      end else if (addr_hit(PADDR_IN, atwsel_pkg::ADDR_TRIG)) begin
         rdata_d[atwsel_pkg::TSEL_BIT] = tsel_q;
         rdata_d[atwsel_pkg::CH_MSB:0] = tch_q;
      end else if (addr_hit(PADDR_IN, atwsel_pkg::ADDR_CTRL)) begin
         rdata_d[atwsel_pkg::CTRL_POL:0] = ctrl_q;
      end else if (addr_hit(PADDR_IN, atwsel_pkg::ADDR_STAT)) begin
         rdata_d[atwsel_pkg::STAT_CH_MSB:atwsel_pkg::STAT_CH_LSB] = ch_q;
         rdata_d[atwsel_pkg::STAT_ACT_BIT] = (state_q == atwsel_pkg::ATWSEL_RUN);
      end
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_B_IN) begin
         PRDATA_OUT <= 32'h0;
      end else if (rd_setup) begin
         PRDATA_OUT <= rdata_d;
      end
   end

   assign use_ded = HAS_DEDICATED & tsel_q;
   always_comb begin
      if (use_ded) begin
         // Reserved codes hold trig_raw low, which still fires in low-level mode
         trig_raw = 1'b0;
         if (tch_q <= atwsel_pkg::DED_LAST) begin
            trig_raw = DEDICATED_TRIGGER_INPUTS_IN[tch_q[atwsel_pkg::DED_SEL_MSB:0]];
         end
      end else begin
         trig_raw = ANALOG_TRIG_IN[tch_q];
      end
   end

   always_comb begin
      DIG_BUF_EN_OUT = 16'h0;
      if (ctrl_q[atwsel_pkg::CTRL_ETE] & ~use_ded) begin
         DIG_BUF_EN_OUT[tch_q] = 1'b1;
      end
   end

   always_comb begin
      case ({ctrl_q[atwsel_pkg::CTRL_LE], ctrl_q[atwsel_pkg::CTRL_POL]})
         2'b00: trig_fire = trig_prev_q & ~trig_raw;
         2'b01: trig_fire = ~trig_prev_q & trig_raw;
         2'b10: trig_fire = ~trig_raw;
         2'b11: trig_fire = trig_raw;
         default: trig_fire = 1'b0;
      endcase
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_B_IN) begin
         trig_prev_q <= 1'b0;
      end else begin
         trig_prev_q <= trig_raw;
      end
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_B_IN) begin
         state_q <= atwsel_pkg::ATWSEL_IDLE;
         ch_q <= atwsel_pkg::CH_ZERO;
         abort_q <= 1'b0;
      end else begin
         abort_q <= wr_wrap | wr_trig;
         if (wr_wrap | wr_trig) begin
            state_q <= atwsel_pkg::ATWSEL_IDLE;
            ch_q <= atwsel_pkg::CH_ZERO;
         end else begin
            case (state_q)
               atwsel_pkg::ATWSEL_IDLE: begin
                  if (start_sw | (ctrl_q[atwsel_pkg::CTRL_ETE] & trig_fire)) begin
                     state_q <= atwsel_pkg::ATWSEL_RUN;
                     ch_q <= atwsel_pkg::CH_ZERO;
                  end
               end
               atwsel_pkg::ATWSEL_RUN: begin
                  if (CONV_DONE_IN) begin
                     if (!ctrl_q[atwsel_pkg::CTRL_MULTI]) begin
                        state_q <= atwsel_pkg::ATWSEL_IDLE;
                     end else if (ch_q >= wrap_q) begin
                        ch_q <= atwsel_pkg::CH_ZERO;
                        state_q <= atwsel_pkg::ATWSEL_IDLE;
                     end else begin
                        ch_q <= ch_q + 4'h1;
                     end
                  end
               end
               default: state_q <= atwsel_pkg::ATWSEL_IDLE;
            endcase
         end
      end
   end

   assign SEQ_ABORT_OUT = abort_q;
   assign SEQ_ACTIVE_OUT = (state_q == atwsel_pkg::ATWSEL_RUN);
   assign CUR_CHANNEL_OUT = ch_q;

   chk_abort_idle: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
      (wr_wrap | wr_trig) |=> (!SEQ_ACTIVE_OUT && SEQ_ABORT_OUT && ch_q == 4'h0))
      else $error("config write did not abort");
   chk_abort_once: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
      !(wr_wrap | wr_trig) |=> !SEQ_ABORT_OUT)
      else $error("abort without config write");
   chk_wrap_zero: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
      (SEQ_ACTIVE_OUT && CONV_DONE_IN && ctrl_q[1] && ch_q == wrap_q && !wr_wrap && !wr_trig)
      |=> ch_q == 4'h0)
      else $error("scan did not wrap");
   chk_scan_step: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
      (SEQ_ACTIVE_OUT && CONV_DONE_IN && ctrl_q[1] && ch_q < wrap_q && !wr_wrap && !wr_trig)
      |=> ch_q == $past(ch_q) + 4'h1)
      else $error("scan did not step");
   chk_trig_read: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
      wr_trig |=> (tsel_q == $past(PWDATA_IN[7]) && tch_q == $past(PWDATA_IN[3:0])))
      else $error("trigger register lost bits");
   chk_buf_enable: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
      (ctrl_q[0] && !use_ded) |-> DIG_BUF_EN_OUT == (16'h1 << tch_q))
      else $error("buffer enable wrong");
   chk_no_start: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
      (!SEQ_ACTIVE_OUT && !ctrl_q[0] && !start_sw) |=> !SEQ_ACTIVE_OUT)
      else $error("start without enable");
   chk_fire_start: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
      (!SEQ_ACTIVE_OUT && ctrl_q[0] && trig_fire && !wr_wrap && !wr_trig) |=> SEQ_ACTIVE_OUT)
      else $error("enabled trigger did not start");
   chk_rise_edge: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
      (ctrl_q[3:2] == 2'b10 && $rose(trig_raw)) |-> trig_fire)
      else $error("rising edge missed");
   chk_fall_edge: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
      (ctrl_q[3:2] == 2'b00 && $fell(trig_raw)) |-> trig_fire)
      else $error("falling edge missed");
   chk_low_level: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
      (ctrl_q[3:2] == 2'b01 && !trig_raw) |-> trig_fire)
      else $error("low level missed");
   chk_analog_src: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
      !use_ded |-> trig_raw == ANALOG_TRIG_IN[tch_q])
      else $error("analog source wrong");
   chk_ded_src: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
      (use_ded && tch_q > 4'h3) |-> !trig_raw)
      else $error("reserved dedicated code fired");
   chk_ded_pick: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
      (use_ded && tch_q <= 4'h3) |-> trig_raw == DEDICATED_TRIGGER_INPUTS_IN[tch_q[1:0]])
      else $error("dedicated input not selected");
endmodule

/* testbench/tb.sv */
// Self-checking bench for the scan wrap and trigger source control block.
// Assumes zero wait state APB answers and a synchronous active low reset.
`timescale 1ns/100ps
module tb;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, done = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwd = 32'h0, rd, prdata;
   logic [15:0] an = 16'h0, buf_en;
   logic [3:0] ded = 4'h0, chan;
   logic err, seen, pready, pslverr, abort, active;
   int bad_count = 0;
   int checks_done = 0;
   int cyc = 0;
   atwsel_top i_dut (.SYS_CLK_IN(clk), .RST_B_IN(rst_b), .PSEL_IN(psel), .PENABLE_IN(pen),
      .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwd), .PSTRB_IN(4'hf),
      .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
      .ANALOG_TRIG_IN(an), .DEDICATED_TRIGGER_INPUTS_IN(ded), .CONV_DONE_IN(done),
      .SEQ_ABORT_OUT(abort), .SEQ_ACTIVE_OUT(active), .CUR_CHANNEL_OUT(chan),
      .DIG_BUF_EN_OUT(buf_en));
   initial forever #25 clk = ~clk;
   task end_of_test;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         bad_count++;
         end_of_test;
      end
   end
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", n, e, g);
         bad_count++;
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task w8(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task pulse;
      @(posedge clk);
      done <= 1'b1;
      @(posedge clk);
      done <= 1'b0;
      w8(2);
   endtask
   task t_regs;
      apb(0, atwsel_pkg::ADDR_WRAP, 0);
      chk("wrap reset", 32'hf, rd);
      chk("ready", 32'h1, 32'(pready));
      apb(0, atwsel_pkg::ADDR_TRIG, 0);
      chk("trig reset", 32'h0, rd);
      apb(0, 12'h010, 0);
      chk("unmapped data", 32'h0, rd);
      chk("unmapped err", 32'h1, 32'(err));
      apb(1, atwsel_pkg::ADDR_WRAP, 32'hffffffff);
      apb(0, atwsel_pkg::ADDR_WRAP, 0);
      chk("wrap bits", 32'hf, rd);
      // Code zero is reserved, so the lowest legal wrap code is used
      apb(1, atwsel_pkg::ADDR_WRAP, 32'h1);
      apb(0, atwsel_pkg::ADDR_WRAP, 0);
      chk("wrap low", 32'h1, rd);
      apb(1, atwsel_pkg::ADDR_TRIG, 32'hff);
      apb(0, atwsel_pkg::ADDR_TRIG, 0);
      chk("trig bits", 32'h8f, rd);
   endtask
   task t_wrap;
      apb(1, atwsel_pkg::ADDR_WRAP, 32'h2);
      apb(1, atwsel_pkg::ADDR_CTRL, 32'h12);
      w8(2);
      chk("scan start", 32'h1, 32'({chan, active}));
      for (int i = 1; i < 3; i++) begin
         pulse;
         chk("scan chan", i, 32'(chan));
         apb(0, atwsel_pkg::ADDR_STAT, 0);
         chk("scan status", (i << 4) | 1, rd);
      end
      pulse;
      chk("scan wrap", 32'h0, 32'({chan, active}));
   endtask
   task t_abort;
      apb(1, atwsel_pkg::ADDR_CTRL, 32'h10);
      w8(2);
      chk("run", 32'h1, 32'(active));
      apb(1, atwsel_pkg::ADDR_TRIG, 32'h05);
      #1 seen = abort;
      w8(1);
      seen = seen | abort;
      chk("abort", 32'h1, 32'(seen));
      w8(4);
      chk("no restart", 32'h0, 32'({abort, active}));
   endtask
   task t_trig;
      apb(1, atwsel_pkg::ADDR_CTRL, 32'h0c);
      an <= 16'h0020;
      w8(3);
      chk("trig off", 32'h0, 32'(active));
      @(posedge clk);
      an <= 16'h0000;
      apb(1, atwsel_pkg::ADDR_CTRL, 32'h0d);
      w8(1);
      chk("buffer", 32'h0020, 32'(buf_en));
      @(posedge clk);
      an <= 16'h0010;
      w8(3);
      chk("wrong chan", 32'h0, 32'(active));
      @(posedge clk);
      an <= 16'h0020;
      w8(3);
      chk("analog fire", 32'h1, 32'(active));
      @(posedge clk);
      an <= 16'h0000;
      pulse;
      apb(1, atwsel_pkg::ADDR_TRIG, 32'h81);
      w8(1);
      chk("no buffer", 32'h0, 32'(buf_en));
      @(posedge clk);
      ded <= 4'h1;
      w8(3);
      chk("wrong input", 32'h0, 32'(active));
      @(posedge clk);
      ded <= 4'h2;
      w8(3);
      chk("ded fire", 32'h1, 32'(active));
      @(posedge clk);
      ded <= 4'h0;
      pulse;
      apb(1, atwsel_pkg::ADDR_TRIG, 32'h84);
      ded <= 4'hf;
      w8(3);
      chk("reserved", 32'h0, 32'(active));
   endtask
   task t_sens;
      apb(1, atwsel_pkg::ADDR_TRIG, 32'h05);
      apb(1, atwsel_pkg::ADDR_CTRL, 32'h09);
      w8(2);
      chk("rise idle", 32'h0, 32'(active));
      @(posedge clk);
      an <= 16'h0020;
      w8(3);
      chk("rise fire", 32'h1, 32'(active));
      pulse;
      chk("rise once", 32'h0, 32'(active));
      apb(1, atwsel_pkg::ADDR_CTRL, 32'h01);
      w8(2);
      chk("fall idle", 32'h0, 32'(active));
      @(posedge clk);
      an <= 16'h0000;
      w8(3);
      chk("fall fire", 32'h1, 32'(active));
      pulse;
      apb(1, atwsel_pkg::ADDR_CTRL, 32'h05);
      w8(2);
      chk("low fire", 32'h1, 32'(active));
      @(posedge clk);
      an <= 16'h0020;
      pulse;
      chk("low stop", 32'h0, 32'(active));
   endtask
   task t_reset;
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      apb(0, atwsel_pkg::ADDR_WRAP, 0);
      chk("wrap after reset", 32'hf, rd);
      chk("idle after reset", 32'h0, 32'({chan, active}));
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      t_regs;
      t_wrap;
      t_abort;
      t_trig;
      t_sens;
      t_reset;
      end_of_test;
   end
endmodule
